// >>> rtl/bdr_pkg.sv
package bdr_pkg;
  // ---------------------------------------------------------------
  // Task-file register indices
  // ---------------------------------------------------------------
  localparam logic [2:0] TF_DATA     = 3'h0;
  localparam logic [2:0] TF_FAULT    = 3'h1;
  localparam logic [2:0] TF_SECCNT   = 3'h2;
  localparam logic [2:0] TF_SECNUM   = 3'h3;
  localparam logic [2:0] TF_CYL_LO   = 3'h4;
  localparam logic [2:0] TF_CYL_HI   = 3'h5;
  localparam logic [2:0] TF_DRVHEAD  = 3'h6;
  localparam logic [2:0] TF_OPCODE   = 3'h7;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RD_BUF   = 8'he4;
  localparam logic [7:0] OP_RD_DMA   = 8'hc8;
  localparam logic [7:0] OP_RD_DMA_R = 8'hc9;
  localparam logic [7:0] OP_RETRY_MASK = 8'hfe;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DH_LBA_BIT   = 6;
  localparam int ST_BSY       = 7;
  localparam int ST_RDY       = 6;
  localparam int ST_DF        = 5;
  localparam int ST_DSC       = 4;
  localparam int ST_DRQ       = 3;
  localparam int ST_COR       = 2;
  localparam int ST_ERR       = 0;
  localparam int ER_CRC       = 7;
  localparam int ER_UNC       = 6;
  localparam int ER_IDN       = 4;
  localparam int ER_ABT       = 2;
  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int WORDS_PER_SECTOR = 256;
  localparam int WIDX_W           = 8;
  localparam logic [8:0] SEC_ZERO_MEANS = 9'h100;
  localparam logic [7:0] STATUS_RST   = 8'h50;
  localparam logic [7:0] DRVHEAD_RST  = 8'ha0;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
endpackage

// >>> rtl/bdr_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bdr_link_if;
  import bdr_pkg::*;
  // Register access strobes, host drives; device drives tf_rdata
  logic       tf_wr;
  logic       tf_rd;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic [7:0] tf_rdata;
  // Data port, 16-bit words
  logic [15:0] data;
  logic        pio_drq;
  logic        pio_ack;
  logic        dmarq;
  logic        dmack;
  logic        intrq;

  modport dev (
    input  tf_wr, tf_rd, tf_addr, tf_wdata, pio_ack, dmack,
    output tf_rdata, data, pio_drq, dmarq, intrq
  );
  modport hst (
    output tf_wr, tf_rd, tf_addr, tf_wdata, pio_ack, dmack,
    input  tf_rdata, data, pio_drq, dmarq, intrq
  );
endinterface
`default_nettype wire

// >>> rtl/bdr_device.sv
// Operation
// RULE1: read-buffer opcode delivers one buffered sector
// RULE2: read-buffer sector moves as 16-bit words
// RULE3: source is last write-buffer region
// RULE4: later media traffic may overwrite region
// RULE5: DMA opcodes read media, send sectors
// RULE6: DMA sectors move as 16-bit words
// RULE7: host arms DMA before writing opcode
// RULE8: DMA words move only under DMARQ
// RULE9: one interrupt after transfer, status valid
// RULE10: uncorrectable sector stops the DMA read
// RULE11: sector count zero means 256
// RULE12: CHS start from sector, cylinder, head
// RULE13: LBA start bits from four registers
// RULE14: retry bit ignored, both opcodes same
// RULE15: leftover sector count reported at end
// RULE16: address registers show last sector; a CRC stop with sectors left steps them one past it
// RULE17: completion status busy, fault, corrected clear
// RULE18: allowed error flags per command
`timescale 1ns/100ps
`default_nettype none
module bdr_device
  import bdr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  bdr_link_if.dev          link,
  // Media side: one sector streams in word by word
  output logic             o_media_req,
  output logic [27:0]      o_media_addr,
  output logic             o_media_lba,
  input  wire logic        i_media_valid,
  input  wire logic [15:0] i_media_word,
  input  wire logic        i_media_last,
  input  wire logic        i_media_unc,
  input  wire logic        i_media_idnf,
  input  wire logic        i_crc_err,
  // Write-buffer fill port, also used by media traffic
  input  wire logic        i_buf_wr,
  input  wire logic [7:0]  i_buf_widx,
  input  wire logic [15:0] i_buf_wdata,
  output logic             o_busy
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_RB_XFER, S_DMA_MEDIA, S_DMA_XFER, S_DONE}
    bdr_state_t;

  bdr_state_t   state_reg;
  logic [15:0]  sbuf [WORDS_PER_SECTOR];
  logic [7:0]   seccnt_reg;
  logic [7:0]   secnum_reg;
  logic [7:0]   cyl_lo_reg;
  logic [7:0]   cyl_hi_reg;
  logic [7:0]   drvhead_reg;
  logic [7:0]   fault_reg;
  logic [7:0]   status_reg;
  logic [8:0]   remain_reg;
  logic [WIDX_W-1:0] widx_reg;
  logic [WIDX_W-1:0] fill_reg;
  logic [15:0]  data_reg;
  logic         intrq_reg;
  logic         lba_reg;
  logic         is_dma_op;
  logic         xfer_word;
  logic         last_word;

  assign is_dma_op = (link.tf_wdata & OP_RETRY_MASK) == OP_RD_DMA; // see RULE14
  assign xfer_word = (state_reg == S_RB_XFER) ? link.pio_ack
                   : (state_reg == S_DMA_XFER) ? link.dmack : 1'b0;
  assign last_word = widx_reg == WIDX_W'(WORDS_PER_SECTOR - 1);
  wire   opc_wr = link.tf_wr && link.tf_addr == TF_OPCODE
                  && state_reg == S_IDLE;

  // ---------------------------------------------------------------
  // Sector buffer; shared with media, so contents may change
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && i_buf_wr) begin
      sbuf[i_buf_widx] <= i_buf_wdata; // see RULE3 see RULE4
    end else if (i_ce && state_reg == S_DMA_MEDIA && i_media_valid) begin
      sbuf[fill_reg] <= i_media_word; // see RULE4
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill_reg <= '0;
    end else if (i_ce) begin
      if (state_reg != S_DMA_MEDIA) begin
        fill_reg <= '0;
      end else if (i_media_valid) begin
        fill_reg <= fill_reg + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg  <= S_IDLE;
      widx_reg   <= '0;
      remain_reg <= '0;
      lba_reg    <= 1'b0;
      fault_reg  <= BYTE_ZERO;
      status_reg <= STATUS_RST;
      intrq_reg  <= 1'b0;
    end else if (i_ce) begin
      if (link.tf_rd && link.tf_addr == TF_OPCODE) begin
        intrq_reg <= 1'b0;
      end
      unique case (state_reg)
        S_IDLE: begin
          if (opc_wr) begin
            fault_reg  <= BYTE_ZERO;
            intrq_reg  <= 1'b0;
            widx_reg   <= '0;
            status_reg[ST_BSY] <= 1'b1;
            status_reg[ST_ERR] <= 1'b0;
            if (link.tf_wdata == OP_RD_BUF) begin
              state_reg <= S_RB_XFER; // see RULE1
              status_reg[ST_DRQ] <= 1'b1;
            end else if (is_dma_op) begin
              state_reg  <= S_DMA_MEDIA; // see RULE5 see RULE7
              lba_reg    <= drvhead_reg[DH_LBA_BIT];
              remain_reg <= (seccnt_reg == BYTE_ZERO) ? SEC_ZERO_MEANS
                            : {1'b0, seccnt_reg}; // see RULE11
            end else begin
              fault_reg[ER_ABT] <= 1'b1;
              state_reg <= S_DONE;
            end
          end
        end
        S_RB_XFER: begin
          if (xfer_word) begin
            widx_reg <= widx_reg + 1'b1; // see RULE2
            if (last_word) begin
              state_reg <= S_DONE;
            end
          end
        end
        S_DMA_MEDIA: begin
          if (i_media_valid && (i_media_unc || i_media_idnf)) begin
            fault_reg[ER_UNC] <= i_media_unc; // see RULE10 see RULE18
            fault_reg[ER_IDN] <= i_media_idnf;
            state_reg <= S_DONE;
          end else if (i_media_valid && i_media_last) begin
            state_reg <= S_DMA_XFER;
            widx_reg  <= '0;
            status_reg[ST_DRQ] <= 1'b1;
          end
        end
        S_DMA_XFER: begin
          if (xfer_word) begin
            widx_reg <= widx_reg + 1'b1; // see RULE6 see RULE8
            if (i_crc_err) begin
              fault_reg[ER_CRC] <= 1'b1; // see RULE18
            end
            if (last_word) begin
              remain_reg <= remain_reg - 9'h001; // see RULE15
              if (remain_reg == 9'h001 || i_crc_err
                  || fault_reg[ER_CRC]) begin
                state_reg <= S_DONE;
              end else begin
                state_reg <= S_DMA_MEDIA;
                status_reg[ST_DRQ] <= 1'b0;
              end
            end
          end
        end
        S_DONE: begin
          state_reg  <= S_IDLE;
          status_reg[ST_BSY] <= 1'b0; // see RULE17
          status_reg[ST_DRQ] <= 1'b0;
          status_reg[ST_DF]  <= 1'b0;
          status_reg[ST_COR] <= 1'b0;
          status_reg[ST_ERR] <= |fault_reg;
          intrq_reg  <= 1'b1; // see RULE9
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address registers: host writes, device reports progress
  // ---------------------------------------------------------------
  wire [27:0] cur_addr = {drvhead_reg[3:0], cyl_hi_reg, cyl_lo_reg,
                          secnum_reg}; // see RULE12 see RULE13
  wire        sector_done = state_reg == S_DMA_XFER && xfer_word
                            && last_word;
  wire [27:0] next_lba = cur_addr + 28'h0000001;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seccnt_reg  <= BYTE_ZERO;
      secnum_reg  <= BYTE_ZERO;
      cyl_lo_reg  <= BYTE_ZERO;
      cyl_hi_reg  <= BYTE_ZERO;
      drvhead_reg <= DRVHEAD_RST;
    end else if (i_ce) begin
      if (link.tf_wr && state_reg == S_IDLE) begin
        unique case (link.tf_addr)
          TF_SECCNT:  seccnt_reg  <= link.tf_wdata;
          TF_SECNUM:  secnum_reg  <= link.tf_wdata;
          TF_CYL_LO:  cyl_lo_reg  <= link.tf_wdata;
          TF_CYL_HI:  cyl_hi_reg  <= link.tf_wdata;
          TF_DRVHEAD: drvhead_reg <= link.tf_wdata;
          default: ;
        endcase
      end else if (sector_done) begin
        seccnt_reg <= 8'(remain_reg - 9'h001); // see RULE15
        // Registers hold last transferred sector, advance only if more
        if (remain_reg != 9'h001) begin
          if (lba_reg) begin
            {drvhead_reg[3:0], cyl_hi_reg, cyl_lo_reg, secnum_reg}
              <= next_lba; // see RULE16
          end else begin
            // Geometry unknown here: CHS steps sector number only
            secnum_reg <= secnum_reg + 8'h01; // see RULE16
          end
        end
      end
    end
  end

  // Data output from a flip-flop, one word per sector slot
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_reg <= WORD_ZERO;
    end else if (i_ce) begin
      data_reg <= sbuf[xfer_word ? WIDX_W'(widx_reg + 1'b1) : widx_reg];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    unique case (link.tf_addr)
      TF_FAULT:   link.tf_rdata = fault_reg;
      TF_SECCNT:  link.tf_rdata = seccnt_reg;
      TF_SECNUM:  link.tf_rdata = secnum_reg;
      TF_CYL_LO:  link.tf_rdata = cyl_lo_reg;
      TF_CYL_HI:  link.tf_rdata = cyl_hi_reg;
      TF_DRVHEAD: link.tf_rdata = drvhead_reg;
      TF_OPCODE:  link.tf_rdata = status_reg;
      default:    link.tf_rdata = BYTE_ZERO;
    endcase
  end

  assign link.data    = data_reg;
  assign link.pio_drq = state_reg == S_RB_XFER;
  assign link.dmarq   = state_reg == S_DMA_XFER; // see RULE8
  assign link.intrq   = intrq_reg;
  assign o_media_req  = state_reg == S_DMA_MEDIA;
  assign o_media_addr = cur_addr;
  assign o_media_lba  = lba_reg;
  assign o_busy       = state_reg != S_IDLE;

endmodule
`default_nettype wire

// >>> rtl/bdr_host.sv
`timescale 1ns/100ps
`default_nettype none
module bdr_host
  import bdr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  bdr_link_if.hst          link,
  // User command port: register write or read
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic [2:0]  i_cmd_addr,
  input  wire logic [7:0]  i_cmd_wdata,
  output logic             o_cmd_ready,
  output logic [7:0]       o_cmd_rdata,
  // DMA channel arm and received words
  input  wire logic        i_dma_arm,
  output logic             o_dma_armed,
  output logic             o_word_valid,
  output logic [15:0]      o_word,
  output logic             o_done
);

  // ---------------------------------------------------------------
  // Register access, one per cycle
  // ---------------------------------------------------------------
  logic        armed_reg;
  logic        wvalid_reg;
  logic [15:0] word_reg;
  logic [7:0]  rdata_reg;
  logic        done_reg;
  wire         dma_opc = i_cmd_valid && i_cmd_write
                         && i_cmd_addr == TF_OPCODE
                         && (i_cmd_wdata & OP_RETRY_MASK) == OP_RD_DMA;

  // DMA opcode is held until the channel is armed
  assign o_cmd_ready   = !dma_opc || armed_reg; // see RULE7
  assign link.tf_wr    = i_cmd_valid && i_cmd_write && o_cmd_ready;
  assign link.tf_rd    = i_cmd_valid && !i_cmd_write;
  assign link.tf_addr  = i_cmd_addr;
  assign link.tf_wdata = i_cmd_wdata;
  assign link.pio_ack  = link.pio_drq;
  assign link.dmack    = link.dmarq && armed_reg; // see RULE8

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_dma_arm) begin
        armed_reg <= 1'b1;
      end else if (link.intrq) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Data word shows one cycle after its acknowledge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wvalid_reg <= 1'b0;
      word_reg   <= WORD_ZERO;
      rdata_reg  <= BYTE_ZERO;
      done_reg   <= 1'b0;
    end else if (i_ce) begin
      wvalid_reg <= link.pio_ack || link.dmack; // see RULE2 see RULE6
      word_reg   <= link.data;
      if (link.tf_rd) begin
        rdata_reg <= link.tf_rdata;
      end
      done_reg <= link.intrq;
    end
  end

  assign o_dma_armed  = armed_reg;
  assign o_word_valid = wvalid_reg;
  assign o_word       = word_reg;
  assign o_cmd_rdata  = rdata_reg;
  assign o_done       = done_reg;

endmodule
`default_nettype wire

// >>> testbench/bdr_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bdr_link_checker
  import bdr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        tf_wr,
  input  wire logic        tf_rd,
  input  wire logic [2:0]  tf_addr,
  input  wire logic [7:0]  tf_wdata,
  input  wire logic [15:0] data,
  input  wire logic        pio_drq,
  input  wire logic        pio_ack,
  input  wire logic        dmarq,
  input  wire logic        dmack,
  input  wire logic        intrq
);
  logic [8:0] pio_cnt;
  logic [8:0] dma_cnt;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  // ---------------------------------------------------------------
  // Word counters, cleared whenever the request drops
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) pio_cnt <= 9'h000;
    else if (!pio_drq) pio_cnt <= 9'h000;
    else if (pio_ack) pio_cnt <= pio_cnt + 9'h001;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) dma_cnt <= 9'h000;
    else if (!dmarq) dma_cnt <= 9'h000;
    else if (dmack) dma_cnt <= dma_cnt + 9'h001;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_dma_under_req: assert property (dmack |-> dmarq)
    else $error("dma acknowledge without request");
  a_pio_under_req: assert property (pio_ack |-> pio_drq)
    else $error("word acknowledge without request");
  a_buf_drq_next: assert property (tf_wr && tf_addr == TF_OPCODE
    && tf_wdata == OP_RD_BUF |=> pio_drq)
    else $error("read buffer did not raise request");
  a_bad_op_quiet: assert property (tf_wr && tf_addr == TF_OPCODE
    && tf_wdata != OP_RD_BUF && (tf_wdata & OP_RETRY_MASK) != OP_RD_DMA
    |=> (!pio_drq && !dmarq)[*4])
    else $error("unknown opcode moved data");
  a_buf_one_sector: assert property ($fell(pio_drq)
    |-> $past(pio_cnt) == 9'h0ff && $past(pio_ack))
    else $error("buffer sector not 256 words");
  a_dma_sector_words: assert property ($fell(dmarq)
    |-> $past(dma_cnt) == 9'h0ff && $past(dmack))
    else $error("dma sector not 256 words");
  a_irq_after_buf: assert property (pio_drq && pio_ack
    && pio_cnt == 9'h0ff |-> ##[1:3] intrq)
    else $error("no interrupt after buffer sector");
  a_irq_no_data: assert property (intrq |-> !pio_drq && !dmarq)
    else $error("interrupt during data phase");
  a_irq_status_clr: assert property (intrq && tf_rd
    && tf_addr == TF_OPCODE |=> !intrq)
    else $error("status read left interrupt set");
  a_dma_data_held: assert property ((dmarq && !dmack) ##1 dmarq
    |-> $stable(data))
    else $error("data changed without acknowledge");
endmodule
`default_nettype wire

// >>> testbench/test_buffer_and_dma_sector_read.sv
`timescale 1ns/100ps
`default_nettype none
module test_buffer_and_dma_sector_read;
  import bdr_pkg::*;
  logic        i_ref_clk, i_reset_n, cmd_valid, cmd_write, dma_arm, buf_wr;
  logic        cmd_ready, word_valid, done, media_req, media_lba, ready_s;
  logic        armed, busy;
  logic        m_valid, m_last, m_unc, m_on, m_cool, unc_en, exp_lba, rd_due;
  logic [2:0]  cmd_addr;
  logic [7:0]  cmd_wdata, buf_widx, cmd_rdata, m_idx;
  logic [15:0] buf_wdata, m_word, word, w;
  logic [27:0] media_addr, m_addr, unc_addr;
  logic [31:0] wq[$], rq[$], aq[$];
  logic [7:0]  bad [3] = '{8'h00, 8'hc7, 8'he5};
  int          fail_count, checked, seed;

  bdr_link_if link_bus();
  bdr_device i_bdr_device(.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_ce(1'b1), .link(link_bus), .o_media_req(media_req),
    .o_media_addr(media_addr), .o_media_lba(media_lba),
    .i_media_valid(m_valid), .i_media_word(m_word), .i_media_last(m_last),
    .i_media_unc(m_unc), .i_media_idnf(1'b0), .i_crc_err(1'b0),
    .i_buf_wr(buf_wr), .i_buf_widx(buf_widx), .i_buf_wdata(buf_wdata),
    .o_busy(busy));
  bdr_host i_bdr_host(.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_ce(1'b1), .link(link_bus), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
    .o_cmd_ready(cmd_ready), .o_cmd_rdata(cmd_rdata), .i_dma_arm(dma_arm),
    .o_dma_armed(armed), .o_word_valid(word_valid), .o_word(word),
    .o_done(done));
  bdr_link_checker i_bdr_link_checker(.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .tf_wr(link_bus.tf_wr), .tf_rd(link_bus.tf_rd),
    .tf_addr(link_bus.tf_addr), .tf_wdata(link_bus.tf_wdata),
    .data(link_bus.data), .pio_drq(link_bus.pio_drq),
    .pio_ack(link_bus.pio_ack), .dmarq(link_bus.dmarq),
    .dmack(link_bus.dmack), .intrq(link_bus.intrq));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] mword(input logic [27:0] a,
                                        input logic [7:0] i);
    return {a[7:0] ^ a[23:16], i ^ a[15:8]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ready is taken from the negedge so the edge update cannot race it
  task automatic reg_access(input logic w, input logic [2:0] a,
                            input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr  <= a;
    cmd_wdata <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (ready_s !== 1'b1 && n < 50);
    if (n == 50) fail_count++;
    cmd_valid <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    reg_access(1'b0, a, BYTE_ZERO);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n == 5000) begin
      fail_count++;
      give_verdict;
    end
  endtask

  task automatic dma_cmd(input logic [7:0] op, input logic lba,
                         input int n, input int us);
    logic [27:0] a0;
    logic [27:0] a;
    logic [27:0] la;
    a0 = 28'($random(seed));
    a0[7] = 1'b0;
    unc_en = us < n;
    exp_lba = lba;
    for (int s = 0; s < n && s <= us; s++) begin
      a = lba ? a0 + 28'(s) : {a0[27:8], a0[7:0] + 8'(s)};
      aq.push_back({4'h0, a});
      la = a;
      if (s == us) unc_addr = a;
      else for (int i = 0; i < 256; i++) wq.push_back({16'h0, mword(a, 8'(i))});
    end
    reg_access(1'b1, TF_SECCNT, 8'(n));
    reg_access(1'b1, TF_SECNUM, a0[7:0]);
    reg_access(1'b1, TF_CYL_LO, a0[15:8]);
    reg_access(1'b1, TF_CYL_HI, a0[23:16]);
    reg_access(1'b1, TF_DRVHEAD, {1'b1, lba, 2'b10, a0[27:24]});
    dma_arm <= 1'b1;
    @(posedge i_ref_clk);
    dma_arm <= 1'b0;
    reg_access(1'b1, TF_OPCODE, op);
    check({31'h0, armed}, 32'h1);
    wait_done;
    check({31'h0, busy}, 32'h0);
    reg_rd(TF_OPCODE, STATUS_RST | 8'(unc_en));
    reg_rd(TF_FAULT, 8'(unc_en) << ER_UNC);
    reg_rd(TF_SECCNT, unc_en ? 8'(n - us) : BYTE_ZERO);
    reg_rd(TF_SECNUM, la[7:0]);
    reg_rd(TF_CYL_LO, la[15:8]);
    reg_rd(TF_CYL_HI, la[23:16]);
    unc_en = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Media stand-in: one sector per request, gap after each
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    m_valid <= 1'b0;
    m_last  <= 1'b0;
    m_unc   <= 1'b0;
    if (m_cool) m_cool <= 1'b0;
    else if (m_on) begin
      m_valid <= 1'b1;
      m_word  <= mword(m_addr, m_idx);
      m_last  <= m_idx == 8'hff;
      m_idx   <= m_idx + 8'h01;
      if (unc_en && m_addr == unc_addr) m_unc <= 1'b1;
      if ((unc_en && m_addr == unc_addr) || m_idx == 8'hff) begin
        m_on   <= 1'b0;
        m_cool <= 1'b1;
      end
    end else if (media_req === 1'b1) begin
      m_on   <= 1'b1;
      m_idx  <= 8'h00;
      m_addr <= media_addr;
      check({4'h0, media_addr}, aq.size() ? aq.pop_front() : 32'hx);
      check({31'h0, media_lba}, {31'h0, exp_lba});
    end
  end

  // ---------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------
  always @(negedge i_ref_clk) begin
    if (word_valid === 1'b1) check({16'h0, word}, wq.size() ? wq.pop_front() : 32'hx);
    if (rd_due) check({24'h0, cmd_rdata}, rq.size() ? rq.pop_front() : 32'hx);
    rd_due = (cmd_valid && !cmd_write && cmd_ready) === 1'b1;
    ready_s = cmd_ready;
  end

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #160000;
    fail_count++;
    give_verdict;
  end

  initial begin
    {i_reset_n, cmd_valid, cmd_write, dma_arm, buf_wr, rd_due} = 6'h00;
    {m_valid, m_last, m_unc, m_on, m_cool, unc_en, exp_lba} = 7'h00;
    {cmd_addr, cmd_wdata, buf_widx, buf_wdata, m_word, m_idx} = 59'h0;
    {m_addr, unc_addr} = 56'h0;
    {fail_count, checked, seed} = {32'h0, 32'h0, 32'd3531};
    repeat (6) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    for (int i = 0; i < 256; i++) begin
      w = 16'($random(seed));
      buf_wr    <= 1'b1;
      buf_widx  <= 8'(i);
      buf_wdata <= w;
      wq.push_back({16'h0, w});
      @(posedge i_ref_clk);
    end
    buf_wr <= 1'b0;
    reg_access(1'b1, TF_OPCODE, OP_RD_BUF);
    wait_done;
    reg_rd(TF_OPCODE, STATUS_RST);
    reg_rd(TF_FAULT, BYTE_ZERO);
    for (int k = 0; k < 3; k++) begin
      reg_access(1'b1, TF_OPCODE, bad[k]);
      wait_done;
      reg_rd(TF_OPCODE, STATUS_RST | 8'h01);
      reg_rd(TF_FAULT, 8'h01 << ER_ABT);
    end
    for (int k = 0; k < 4; k++) dma_cmd(k[0] ? OP_RD_DMA_R : OP_RD_DMA, k[1], 2, 9);
    dma_cmd(OP_RD_DMA, 1'b1, 3, 1);
    repeat (4) @(posedge i_ref_clk);
    check(32'(wq.size() + aq.size()), 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
